// ===== srp_pkg.sv
`default_nettype none
package srp_pkg;
  localparam logic [6:0] SRP_ADDR_RATIO_HI = 7'h12;
  localparam logic [6:0] SRP_ADDR_RATIO_LO = 7'h13;
  localparam logic [6:0] SRP_ADDR_PC_HI = 7'h14;
  localparam logic [6:0] SRP_ADDR_PC_LO = 7'h15;
  localparam logic [6:0] SRP_ADDR_PD_HI = 7'h16;
  localparam logic [6:0] SRP_ADDR_PD_LO = 7'h17;
  localparam int SRP_ADDR_W = 7;
  localparam int SRP_DATA_W = 8;
  localparam int SRP_RATIO_W = 15;
  localparam int SRP_PRE_W = 16;
  localparam int SRP_RATIO_HI_LSB = 8;
  localparam int SRP_RATIO_HI_MSB = 14;
  localparam int SRP_RATIO_LO_MSB = 7;
  localparam logic [7:0] SRP_RDATA_RESET = 8'h00;
  localparam logic [14:0] SRP_RATIO_RESET = 15'h0000;
  localparam logic [15:0] SRP_WORD_RESET = 16'h0000;

  typedef struct packed {
    logic [6:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } srp_req_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] pd;
    logic [15:0] pc_b;
  } srp_pre_t;

  function automatic logic [7:0] srp_byte(input logic [15:0] word, input logic high);
    srp_byte = high ? word[15:8] : word[7:0];
  endfunction
endpackage
`default_nettype wire

// ===== srp_word_hold.sv
`default_nettype none
module srp_word_hold
  import srp_pkg::*;
#(
  parameter int W = SRP_PRE_W
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // control
  input wire logic i_load,
  input wire logic i_clear,
  input wire logic [W-1:0] i_data,
  // held word
  output logic [W-1:0] o_word
);
  logic [W-1:0] next_word;

  // clear wins: a stale word must never show once non-audio is withdrawn
  always_comb begin
    next_word = o_word;
    if (i_clear) begin
      next_word = '0;
    end else if (i_load) begin
      next_word = i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_word <= '0;
    end else begin
      o_word <= next_word;
    end
  end

  a_hold_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_load && !i_clear) |=> (o_word == $past(i_data)))
    else $error("held word did not take loaded data");
  a_hold_clear: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_clear |=> (o_word == '0))
    else $error("held word not cleared");
  a_hold_steady: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!i_load && !i_clear) |=> $stable(o_word))
    else $error("held word changed without load");
endmodule
`default_nettype wire

// ===== srp_readback.sv
`default_nettype none
// How it works
// - ratio high register holds ratio bits 14..8 in bits 6..0; bit 7 zero.
// - ratio low register holds ratio bits 7..0 across the whole byte.
// - ratio registers ignore writes; reported ratio never changes from software.
// - pc high register returns captured pc word's high byte under non-audio.
// - pc low register returns captured pc word's low byte under non-audio.
// - pd register pair returns captured pd word, high and low bytes.
// - all four preamble registers read zero without detected non-audio data.
// - in per-subframe mode the pd pair carries channel B's pc word.
module srp_readback
  import srp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // register access
  input wire srp_req_t i_req,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // converter ratio
  input wire logic [14:0] i_ratio,
  // receiver preambles
  input wire logic i_nonaudio,
  input wire logic i_subframe_mode,
  input wire logic i_pre_capture,
  input wire srp_pre_t i_pre
);
  logic [14:0] ratio_q;
  logic [14:0] next_ratio;
  logic [15:0] pc_word;
  logic [15:0] pd_word;
  logic [15:0] pd_source;
  logic pre_load;
  logic pre_clear;
  logic [7:0] next_rdata;
  logic next_rvalid;

  // both words load on the same strobe, so pc and pd always belong together
  assign pre_load = i_pre_capture && i_nonaudio;
  assign pre_clear = !i_nonaudio;
  // both bytes of pd pair follow channel B pc word in subframe mode
  assign pd_source = i_subframe_mode ? i_pre.pc_b : i_pre.pd;

  srp_word_hold #(.W(SRP_PRE_W)) u_pc_hold (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_load(pre_load),
    .i_clear(pre_clear),
    .i_data(i_pre.pc),
    .o_word(pc_word)
  );

  srp_word_hold #(.W(SRP_PRE_W)) u_pd_hold (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_load(pre_load),
    .i_clear(pre_clear),
    .i_data(pd_source),
    .o_word(pd_word)
  );

  // ratio tracks the converter only; the write path never reaches it
  always_comb begin
    next_ratio = i_ratio;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ratio_q <= SRP_RATIO_RESET;
    end else begin
      ratio_q <= next_ratio;
    end
  end

  // read mux; writes are accepted silently and discarded
  always_comb begin
    next_rvalid = i_req.rd;
    next_rdata = SRP_RDATA_RESET;
    if (i_req.rd) begin
      unique case (i_req.addr)
        SRP_ADDR_RATIO_HI: next_rdata = {1'b0, ratio_q[SRP_RATIO_HI_MSB:SRP_RATIO_HI_LSB]};
        SRP_ADDR_RATIO_LO: next_rdata = ratio_q[SRP_RATIO_LO_MSB:0];
        SRP_ADDR_PC_HI: next_rdata = i_nonaudio ? srp_byte(pc_word, 1'b1) : 8'h00;
        SRP_ADDR_PC_LO: next_rdata = i_nonaudio ? srp_byte(pc_word, 1'b0) : 8'h00;
        SRP_ADDR_PD_HI: next_rdata = i_nonaudio ? srp_byte(pd_word, 1'b1) : 8'h00;
        SRP_ADDR_PD_LO: next_rdata = i_nonaudio ? srp_byte(pd_word, 1'b0) : 8'h00;
        default: next_rdata = SRP_RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= SRP_RDATA_RESET;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rdata <= next_rdata;
      o_reg_rvalid <= next_rvalid;
    end
  end

  a_ratio_high_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && i_req.addr == SRP_ADDR_RATIO_HI) |=>
      (o_reg_rvalid && o_reg_rdata == {1'b0, $past(i_ratio[14:8], 2)}))
    else $error("ratio high byte wrong");
  a_ratio_low_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && i_req.addr == SRP_ADDR_RATIO_LO) |=>
      (o_reg_rvalid && o_reg_rdata == $past(ratio_q[7:0])))
    else $error("ratio low byte wrong");
  a_ratio_write_ignored: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.wr && i_req.addr == SRP_ADDR_RATIO_LO) |=> (ratio_q == $past(i_ratio)))
    else $error("write disturbed ratio");
  a_pc_high_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && i_req.addr == SRP_ADDR_PC_HI && i_nonaudio) |=>
      (o_reg_rdata == $past(pc_word[15:8])))
    else $error("pc high byte wrong");
  a_pc_low_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && i_req.addr == SRP_ADDR_PC_LO && i_nonaudio) |=>
      (o_reg_rdata == $past(pc_word[7:0])))
    else $error("pc low byte wrong");
  a_pd_pair_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && i_req.addr == SRP_ADDR_PD_LO && i_nonaudio) |=>
      (o_reg_rdata == $past(pd_word[7:0])))
    else $error("pd low byte wrong");
  a_audio_reads_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && !i_nonaudio && i_req.addr >= SRP_ADDR_PC_HI &&
      i_req.addr <= SRP_ADDR_PD_LO) |=> (o_reg_rvalid && o_reg_rdata == 8'h00))
    else $error("preamble read not zero outside non-audio");
  a_subframe_pd_source: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (pre_load && i_subframe_mode) |=> (pd_word == $past(i_pre.pc_b)))
    else $error("pd pair not loaded from channel B pc");
  a_pair_coherent: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (!i_pre_capture && i_nonaudio) [*2] |-> ($stable(pc_word) && $stable(pd_word)))
    else $error("preamble word moved without capture");

  a_rvalid_follows_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_req.rd
      |=> o_reg_rvalid)
    else $error("read not answered");

  a_rvalid_idle_low: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_req.rd
      |=> (!o_reg_rvalid && o_reg_rdata == 8'h00))
    else $error("read answer without read");

  a_read_wins_write: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && i_req.wr)
      |=> o_reg_rvalid)
    else $error("read lost to write");

  a_ratio_high_bit7: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && i_req.addr == SRP_ADDR_RATIO_HI)
      |=> !o_reg_rdata[7])
    else $error("reserved ratio bit not zero");

  a_ratio_tracks: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_req.wr
      |=> (ratio_q == $past(i_ratio)))
    else $error("ratio did not follow converter");

  a_unmapped_zero: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && (i_req.addr < SRP_ADDR_RATIO_HI || i_req.addr > SRP_ADDR_PD_LO))
      |=> (o_reg_rvalid && o_reg_rdata == 8'h00))
    else $error("unmapped read not zero");

  a_pd_high_read: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.rd && i_req.addr == SRP_ADDR_PD_HI && i_nonaudio)
      |=> (o_reg_rdata == $past(pd_word[15:8])))
    else $error("pd high byte wrong");

  a_normal_pd_source: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (pre_load && !i_subframe_mode)
      |=> (pd_word == $past(i_pre.pd)))
    else $error("pd pair not loaded from pd word");

  a_pc_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    pre_load
      |=> (pc_word == $past(i_pre.pc)))
    else $error("pc word not captured");

  a_pc_low_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    pre_load
      |=> (pc_word[7:0] == $past(i_pre.pc[7:0])))
    else $error("pc low byte not captured");

  a_clear_pc: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_nonaudio
      |=> (pc_word == '0))
    else $error("pc word kept outside non-audio");

  a_clear_pd: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_nonaudio
      |=> (pd_word == '0))
    else $error("pd word kept outside non-audio");

  a_capture_refused: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_pre_capture && !i_nonaudio)
      |=> (pc_word == '0 && pd_word == '0))
    else $error("capture taken outside non-audio");

  a_pair_loaded_together: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    pre_load
      |=> (pc_word == $past(i_pre.pc) && pd_word == $past(pd_source)))
    else $error("preamble pair not loaded together");

  a_pre_write_ignored: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_req.wr && !pre_load && i_nonaudio)
      |=> ($stable(pc_word) && $stable(pd_word)))
    else $error("write disturbed preamble word");

endmodule
`default_nettype wire

// ===== src_ratio_preamble_readback_test.sv
`default_nettype none
module src_ratio_preamble_readback_test
  import srp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, exp, got) begin \
    checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
    end \
  end

  logic i_clk;
  logic i_arst_n;
  srp_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic [14:0] ratio;
  logic nonaudio;
  logic subf;
  logic cap;
  srp_pre_t pre;
  int err_total = 0;
  int checks = 0;

  srp_readback dut (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_req(req),
    .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid),
    .i_ratio(ratio),
    .i_nonaudio(nonaudio),
    .i_subframe_mode(subf),
    .i_pre_capture(cap),
    .i_pre(pre)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // answer lands one edge after the request, so look just past that edge
  task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string nm);
    @(posedge i_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge i_clk);
    req.rd <= 1'b0;
    #1;
    `CHK(nm, {1'b1, exp}, {rvalid, rdata})
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge i_clk);
    req.wr <= 1'b0;
  endtask

  task automatic grab(input logic na, input logic sm);
    @(posedge i_clk);
    nonaudio <= na;
    subf <= sm;
    cap <= 1'b1;
    @(posedge i_clk);
    cap <= 1'b0;
  endtask

  initial begin
    #(400 * 40);
    err_total++;
    report_and_stop();
  end

  initial begin
    i_arst_n = 1'b0;
    req = '0;
    ratio = 15'h7F81;
    nonaudio = 1'b0;
    subf = 1'b0;
    cap = 1'b0;
    pre = {16'hABCD, 16'h1234, 16'h5E6F};
    repeat (12) @(posedge i_clk);
    i_arst_n <= 1'b1;
    rd(SRP_ADDR_RATIO_HI, 8'h7F, "ratio_hi");
    rd(SRP_ADDR_RATIO_LO, 8'h81, "ratio_lo");
    wr(SRP_ADDR_RATIO_HI, 8'hFF);
    wr(SRP_ADDR_RATIO_LO, 8'h00);
    rd(SRP_ADDR_RATIO_HI, 8'h7F, "ratio_hi_wr");
    rd(SRP_ADDR_RATIO_LO, 8'h81, "ratio_lo_wr");
    // ratio is live, so a new converter value must show
    @(posedge i_clk);
    ratio <= 15'h1A5C;
    rd(SRP_ADDR_RATIO_HI, 8'h1A, "ratio_hi_new");
    rd(SRP_ADDR_RATIO_LO, 8'h5C, "ratio_lo_new");
    // capture without non-audio must be dropped
    grab(1'b0, 1'b0);
    rd(SRP_ADDR_PC_HI, 8'h00, "pc_hi_idle");
    rd(SRP_ADDR_PD_LO, 8'h00, "pd_lo_idle");
    grab(1'b1, 1'b0);
    rd(SRP_ADDR_PC_HI, 8'hAB, "pc_hi");
    rd(SRP_ADDR_PC_LO, 8'hCD, "pc_lo");
    rd(SRP_ADDR_PD_HI, 8'h12, "pd_hi");
    rd(SRP_ADDR_PD_LO, 8'h34, "pd_lo");
    wr(SRP_ADDR_PC_HI, 8'hFF);
    rd(SRP_ADDR_PC_HI, 8'hAB, "pc_hi_wr");
    grab(1'b1, 1'b1);
    rd(SRP_ADDR_PD_HI, 8'h5E, "pcb_hi");
    rd(SRP_ADDR_PD_LO, 8'h6F, "pcb_lo");
    rd(SRP_ADDR_PC_LO, 8'hCD, "pc_lo_sub");
    rd(7'h7F, 8'h00, "unmapped");
    grab(1'b0, 1'b0);
    rd(SRP_ADDR_PC_LO, 8'h00, "pc_lo_drop");
    rd(SRP_ADDR_PD_HI, 8'h00, "pd_hi_drop");
    report_and_stop();
  end
endmodule
`default_nettype wire
